/* File: hdl/sscp_defs.svh */
// Function
// - Sweep mode uses start, stop, hold inputs
// - Start fall restarts sweep, ORed trigger
// - Stop fall ends running sweep
// - Hold fall freezes, next fall resumes sweep
// - Sequence mode uses four control inputs
// - Setting selects start or state branch
// - Start fall launches sequence, ORed trigger
// - Low at step end branches to destination
// - Stop fall ends running sequence
// - Hold fall freezes, rise resumes sequence
// - Event fall branches to destination step
// - Drive per-step 4-bit code during sequence
// - Code bit0 on lowest output line
// - General mode: outputs writable, inputs readable
// - Setting disables connector control inputs
// - Trigger input polarity is configurable
`ifndef SSCP_DEFS_SVH
`define SSCP_DEFS_SVH
`define SSCP_ADDR_CTRL      12'h000
`define SSCP_ADDR_STATUS    12'h004
`define SSCP_ADDR_GPOUT     12'h008
`define SSCP_ADDR_GPIN      12'h00C
`define SSCP_ADDR_STEPCNT   12'h010
`define SSCP_ADDR_STEPTAB   12'h040
`define SSCP_ADDR_TAB_END   12'h07C
`define SSCP_CTRL_MODE_LO   0
`define SSCP_CTRL_MODE_HI   1
`define SSCP_CTRL_BRANCH    2
`define SSCP_CTRL_INDIS     3
`define SSCP_CTRL_TRIGPOL   4
`define SSCP_CTRL_RESET     32'h0000_0008
`define SSCP_STEP_LEN_LO    0
`define SSCP_STEP_LEN_HI    15
`define SSCP_STEP_CODE_LO   16
`define SSCP_STEP_CODE_HI   19
`define SSCP_STEP_DST_LO    20
`define SSCP_STEP_DST_HI    23
`define SSCP_STEP_EVD_LO    24
`define SSCP_STEP_EVD_HI    27
`define SSCP_STEP_LAST      28
`define SSCP_TAB_IDX_LO     2
`define SSCP_TAB_IDX_HI     5
`endif

/* File: hdl/sscp_pkg.sv */
`default_nettype none
package sscp_pkg;
  typedef enum logic [1:0] {
    SSCP_MODE_SWEEP = 2'b00,
    SSCP_MODE_SEQ   = 2'b01,
    SSCP_MODE_GPIO  = 2'b10,
    SSCP_MODE_OFF   = 2'b11
  } sscp_mode_t;
  typedef enum logic [1:0] {
    SSCP_IDLE = 2'b00,
    SSCP_RUN  = 2'b01,
    SSCP_HOLD = 2'b10
  } sscp_state_t;
endpackage
`default_nettype wire

/* File: hdl/sscp_port.sv */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "sscp_defs.svh"
`default_nettype none
module sscp_port #(
  parameter int STEPS = 16
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalTriggerInput,
  input  wire logic        startIn,
  input  wire logic        stopIn,
  input  wire logic        holdIn,
  input  wire logic        eventIn,
  output logic      [3:0]  stepCode,
  output logic             engineRunning,
  output logic             engineHeld,
  output logic             sweepRestart
);
  import sscp_pkg::*;

  typedef struct packed {
    logic [4:0][2:0]        sync;
    logic [31:0]            ctrl;
    logic [3:0]             gpOut;
    logic [STEPS-1:0][31:0] tab;
    sscp_state_t            state;
    logic [3:0]             step;
    logic [15:0]            cnt;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [3:0]             code;
    logic                   restart;
    logic [4:0]             filt;
    logic                   running;
    logic                   held;
  } sscp_state_s_t;

  sscp_state_s_t s_reg;
  sscp_state_s_t s_next;

  // Index of an aligned step-table word
  function automatic logic [3:0] tabIndex(input logic [11:0] a);
    tabIndex = a[`SSCP_TAB_IDX_HI:`SSCP_TAB_IDX_LO];
  endfunction

  function automatic logic inTab(input logic [11:0] a);
    inTab = (a >= `SSCP_ADDR_STEPTAB) && (a <= `SSCP_ADDR_TAB_END) && (a[1:0] == 2'b00);
  endfunction

  logic [4:0] pins;
  assign pins = {externalTriggerInput, eventIn, holdIn, stopIn, startIn};

  sscp_mode_t  mode;
  logic        inEnable;
  logic        trigAct;
  logic [4:0]  lvl;
  logic [4:0]  agree;
  logic [4:0]  fall;
  logic [4:0]  rise;
  logic        startFall;
  logic        seqStart;
  logic        startLow;
  logic        stepEnd;
  logic [31:0] cur;
  logic        access;

  assign mode     = sscp_mode_t'(s_reg.ctrl[`SSCP_CTRL_MODE_HI:`SSCP_CTRL_MODE_LO]);
  assign inEnable = ~s_reg.ctrl[`SSCP_CTRL_INDIS];
  assign cur      = s_reg.tab[s_reg.step];
  assign access   = psel & penable;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gEdge
      // Stages 2 and 3 must agree, so a one-clock glitch never counts
      assign agree[g] = (s_reg.sync[g][1] == s_reg.sync[g][2]);
      assign lvl[g]   = s_reg.filt[g];
      assign fall[g]  = inEnable & agree[g] & s_reg.filt[g] & ~s_reg.sync[g][1];
      assign rise[g]  = inEnable & agree[g] & ~s_reg.filt[g] & s_reg.sync[g][1];
    end
  endgenerate

  // Trigger edge in active polarity, ORed with start pin
  assign trigAct   = s_reg.ctrl[`SSCP_CTRL_TRIGPOL] ? rise[4] : fall[4];
  assign startFall = fall[0] | trigAct;
  // Trigger still starts a sequence when the start pin acts as branch
  assign seqStart  = trigAct | (~s_reg.ctrl[`SSCP_CTRL_BRANCH] & fall[0]);
  assign startLow  = inEnable & ~lvl[0];
  assign stepEnd   = (s_reg.state == SSCP_RUN) &&
                     (s_reg.cnt >= cur[`SSCP_STEP_LEN_HI:`SSCP_STEP_LEN_LO]);

  always_comb begin
    s_next         = s_reg;
    s_next.restart = 1'b0;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    for (int i = 0; i < 5; i++) begin
      s_next.sync[i] = {s_reg.sync[i][1:0], pins[i]};
      if (s_reg.sync[i][1] == s_reg.sync[i][2]) begin
        s_next.filt[i] = s_reg.sync[i][1];
      end
    end

    // Read data fetched in setup so it stands together with pready
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      if (!pwrite) begin
        s_next.prdata = 32'h0000_0000;
        case (paddr)
          `SSCP_ADDR_CTRL:    s_next.prdata = s_reg.ctrl;
          `SSCP_ADDR_STATUS:  s_next.prdata = {26'h0, s_reg.code, s_reg.state};
          `SSCP_ADDR_GPOUT:   s_next.prdata = {28'h0, s_reg.gpOut};
          `SSCP_ADDR_GPIN:    s_next.prdata = {28'h0, lvl[0], lvl[1], lvl[2], lvl[3]};
          `SSCP_ADDR_STEPCNT: s_next.prdata = {12'h0, s_reg.step, s_reg.cnt};
          default: begin
            if (inTab(paddr)) begin
              s_next.prdata = s_reg.tab[tabIndex(paddr)];
            end
          end
        endcase
      end
    end
    if (access && s_reg.pready && pwrite) begin
      case (paddr)
        `SSCP_ADDR_CTRL: s_next.ctrl = pwdata;
        `SSCP_ADDR_GPOUT: s_next.gpOut = pwdata[3:0];
        default: begin
          if (inTab(paddr)) begin
            s_next.tab[tabIndex(paddr)] = pwdata;
          end
        end
      endcase
    end

    case (mode)
      SSCP_MODE_SWEEP: begin
        s_next.code = 4'h0;
        if (startFall) begin
          s_next.state   = SSCP_RUN;
          s_next.restart = 1'b1;
        end else if (fall[1]) begin
          s_next.state = SSCP_IDLE;
        end else if (fall[2] && s_reg.state == SSCP_RUN) begin
          s_next.state = SSCP_HOLD;
        end else if (fall[2] && s_reg.state == SSCP_HOLD) begin
          s_next.state = SSCP_RUN;
        end
      end
      SSCP_MODE_SEQ: begin
        s_next.code = cur[`SSCP_STEP_CODE_HI:`SSCP_STEP_CODE_LO];
        if (s_reg.state == SSCP_RUN) begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
        if (seqStart) begin
          s_next.state = SSCP_RUN;
          s_next.step  = 4'h0;
          s_next.cnt   = 16'h0000;
        end else if (fall[1]) begin
          s_next.state = SSCP_IDLE;
        end else if (fall[2] && s_reg.state == SSCP_RUN) begin
          s_next.state = SSCP_HOLD;
        end else if (rise[2] && s_reg.state == SSCP_HOLD) begin
          s_next.state = SSCP_RUN;
        end else if (fall[3] && s_reg.state != SSCP_IDLE) begin
          s_next.step = cur[`SSCP_STEP_EVD_HI:`SSCP_STEP_EVD_LO];
          s_next.cnt  = 16'h0000;
        end else if (stepEnd) begin
          s_next.cnt = 16'h0000;
          if (s_reg.ctrl[`SSCP_CTRL_BRANCH] && startLow) begin
            s_next.step = cur[`SSCP_STEP_DST_HI:`SSCP_STEP_DST_LO];
          end else if (cur[`SSCP_STEP_LAST]) begin
            s_next.state = SSCP_IDLE;
          end else begin
            s_next.step = s_reg.step + 4'h1;
          end
        end
      end
      SSCP_MODE_GPIO: begin
        s_next.state = SSCP_IDLE;
        s_next.code  = s_reg.gpOut;
      end
      default: begin
        s_next.state = SSCP_IDLE;
        s_next.code  = 4'h0;
      end
    endcase
    // Status outputs kept as flops of their own
    s_next.running = (s_next.state == SSCP_RUN);
    s_next.held    = (s_next.state == SSCP_HOLD);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg      <= '0;
      s_reg.sync <= '1;
      s_reg.filt <= '1;
      s_reg.ctrl <= `SSCP_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata        = s_reg.prdata;
  assign pready        = s_reg.pready;
  assign pslverr       = s_reg.pslverr;
  assign stepCode      = s_reg.code;
  assign engineRunning = s_reg.running;
  assign engineHeld    = s_reg.held;
  assign sweepRestart  = s_reg.restart;
endmodule
`default_nettype wire

/* File: sim/sscp_port_sva.sv */
`default_nettype none
module sscp_port_sva (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       holdIn,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [3:0] stepCode,
  input wire logic       engineRunning,
  input wire logic       engineHeld,
  input wire logic       sweepRestart
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [3:0] sinceHold;
  // Saturates so a long quiet spell cannot wrap
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) sinceHold <= 4'hF;
    else if ($fell(holdIn)) sinceHold <= 4'h0;
    else if (sinceHold != 4'hF) sinceHold <= sinceHold + 4'h1;
  property p_noErr; pslverr == 1'b0; endproperty
  a_noErr: assert property (p_noErr) else $error("pslverr set");
  property p_rdyAcc; pready |-> psel && penable; endproperty
  a_rdyAcc: assert property (p_rdyAcc) else $error("pready out of access");
  property p_rdyLat; psel && !penable |=> pready; endproperty
  a_rdyLat: assert property (p_rdyLat) else $error("pready late");
  property p_rdyOne; pready |=> !pready; endproperty
  a_rdyOne: assert property (p_rdyOne) else $error("pready too long");
  property p_excl; !(engineRunning && engineHeld); endproperty
  a_excl: assert property (p_excl) else $error("run and hold");
  property p_rstOne; sweepRestart |=> !sweepRestart; endproperty
  a_rstOne: assert property (p_rstOne) else $error("restart too long");
  property p_holdCause; $rose(engineHeld) |-> sinceHold <= 4'h6; endproperty
  a_holdCause: assert property (p_holdCause) else $error("hold without pin");
  property p_heldCode; engineHeld ##1 engineHeld |-> $stable(stepCode); endproperty
  a_heldCode: assert property (p_heldCode) else $error("code moved in hold");
  c_restart: cover property (sweepRestart);
  c_held: cover property ($rose(engineHeld));
  c_branch: cover property (engineRunning && stepCode == 4'hC);
endmodule
bind sscp_port sscp_port_sva chk (
  .mclk          (mclk),
  .reset_n       (reset_n),
  .psel          (psel),
  .penable       (penable),
  .holdIn        (holdIn),
  .pready        (pready),
  .pslverr       (pslverr),
  .stepCode      (stepCode),
  .engineRunning (engineRunning),
  .engineHeld    (engineHeld),
  .sweepRestart  (sweepRestart)
);
`default_nettype wire

/* File: sim/sscp_pins.sv */
`default_nettype none
module sscp_pins (
  input  wire logic       mclk,
  output logic      [4:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit 4 is the trigger; all lines pulled up, idle high
  initial lines = 5'h1F;
  task automatic drive(input logic [4:0] v);
    @(posedge mclk);
    lines <= v;
  endtask
  // Two clocks low, the narrowest pulse the synchronizer takes
  task automatic pulse(input logic [4:0] m);
    drive(~m);
    @(posedge mclk);
    drive(5'h1F);
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`include "sscp_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, engineRunning, engineHeld, sweepRestart;
  logic [3:0]  stepCode;
  logic [4:0]  lines;
  int          errTotal = 0, cmpCount = 0;
  int          nRestart = 0;
  always #20 mclk = ~mclk;
  // Restart is a one-clock pulse, so it is counted rather than polled
  always @(posedge mclk) if (sweepRestart === 1'b1) nRestart <= nRestart + 1;
  sscp_pins pins (.mclk(mclk), .lines(lines));
  sscp_port dut (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .externalTriggerInput (lines[4]),
    .startIn              (lines[3]),
    .stopIn               (lines[2]),
    .holdIn               (lines[1]),
    .eventIn              (lines[0]),
    .stepCode             (stepCode),
    .engineRunning        (engineRunning),
    .engineHeld           (engineHeld),
    .sweepRestart         (sweepRestart)
  );
  task automatic reportAndStop;
    if (errTotal == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errTotal++;
      reportAndStop();
    end
  endtask
  task automatic wait6;
    repeat (6) @(posedge mclk);
  endtask
  task automatic waitIdle;
    int n;
    for (n = 0; n < 300 && engineRunning !== 1'b0; n++) @(posedge mclk);
    chk("idle", 0, engineRunning);
    if (n == 300) reportAndStop();
  endtask
  task automatic tRegs;
    apb(1'b0, `SSCP_ADDR_CTRL, 32'h0);
    chk("ctrl reset", `SSCP_CTRL_RESET, q);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 0, q);
  endtask
  task automatic tSweep;
    pins.pulse(5'h08);
    chk("disabled", 0, engineRunning);
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h0);
    pins.pulse(5'h08);
    chk("sweep start", 1, engineRunning);
    chk("sweep code", 0, stepCode);
    pins.pulse(5'h02);
    chk("sweep held", 1, engineHeld);
    pins.pulse(5'h02);
    chk("sweep resumed", 1, engineRunning);
    pins.pulse(5'h04);
    chk("sweep stop", 0, engineRunning);
    pins.pulse(5'h10);
    chk("trigger start", 1, engineRunning);
    pins.pulse(5'h04);
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h10);
    pins.drive(5'h0F);
    wait6();
    chk("trigger fall", 0, engineRunning);
    pins.drive(5'h1F);
    wait6();
    chk("trigger rise", 1, engineRunning);
    pins.pulse(5'h04);
    chk("restarts", 3, nRestart);
  endtask
  task automatic tSeq;
    apb(1'b1, `SSCP_ADDR_STEPTAB, 32'h0225_0060);
    apb(1'b1, `SSCP_ADDR_STEPTAB + 12'h004, 32'h100A_0008);
    apb(1'b1, `SSCP_ADDR_STEPTAB + 12'h008, 32'h100C_0040);
    apb(1'b0, `SSCP_ADDR_STEPTAB, 32'h0);
    chk("table read", 32'h0225_0060, q);
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h1);
    pins.pulse(5'h08);
    chk("first code", 4'h5, stepCode);
    pins.drive(5'h1D);
    wait6();
    chk("seq held", 1, engineHeld);
    apb(1'b0, `SSCP_ADDR_STATUS, 32'h0);
    chk("status held", 32'h16, q);
    pins.drive(5'h1F);
    wait6();
    chk("seq resumed", 1, engineRunning);
    pins.pulse(5'h01);
    chk("event dest", 4'hC, stepCode);
    waitIdle();
  endtask
  task automatic tBranch;
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h5);
    pins.drive(5'h07);
    pins.drive(5'h07);
    pins.drive(5'h17);
    repeat (110) @(posedge mclk);
    chk("state dest", 4'hC, stepCode);
    pins.drive(5'h1F);
    waitIdle();
  endtask
  task automatic tGpio;
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h2);
    apb(1'b1, `SSCP_ADDR_GPOUT, 32'h9);
    pins.drive(5'h16);
    wait6();
    chk("gp out", 4'h9, stepCode);
    apb(1'b0, `SSCP_ADDR_GPIN, 32'h0);
    chk("gp in", 32'h6, q);
    apb(1'b1, `SSCP_ADDR_CTRL, 32'h3);
    wait6();
    chk("off code", 0, stepCode);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    tRegs();
    tSweep();
    tSeq();
    tBranch();
    tGpio();
    reportAndStop();
  end
endmodule
`default_nettype wire
